// *** logic/scx_regs.sv ***
// system control exception, reset control and sleep control registers on AXI4-Lite
//
// Summary of operation
// - writing 1 to service call clear bit drops its pending state; 0 does nothing.
// - writing 1 to bit 26 pends the tick exception; reads show tick pending.
// - writing 1 to write-only bit 25 removes tick pending; 0 leaves it.
// - bit 23 reads 1 when a pending exception is taken on leaving debug halt.
// - bit 22 reads 1 while any interrupt is pending, excluding NMI and faults.
// - bits 17:12 give highest priority enabled pending exception number, else zero.
// - bits 5:0 give the active exception number, zero in thread mode.
// - reset control register reads 0xFA05_0000 after reset, control bits clear.
// - keyed write of 1 to bit 2 raises the chip-wide reset request.
// - reset request bit is write only and clears during the reset it causes.
// - writing 1 to write-only bit 1 wipes all exception active state.
// - sleep bit 4 at 0 wakes on enabled only; at 1 on every interrupt.
// - new pending wakes a waiting core, else latched for the next wait.
// - a waiting core also wakes on send-event or an external event.
// - sleep bit 2 selects plain sleep at 0 and deep sleep at 1.
// - sleep bit 1 set makes handler return to thread mode enter sleep.
// - sleep control register resets to zero.
//
// Design decision made here: the AXI4-Lite register port.
`default_nettype none
`include "scx_defines.svh"
module scx_regs #(
  parameter int NUM_IRQ = 32,
  parameter int ADDR_W  = 12
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [NUM_IRQ-1:0]        irq_pending,
  input  wire logic [NUM_IRQ-1:0]        irq_enable,
  input  wire scx_pkg::scx_core_status_t core_status,
  input  wire logic                      external_event,
  input  wire logic                      tick_event,
  input  wire logic                      service_call_taken,
  input  wire logic                      tick_taken,
  output var  logic                      service_call_pend_q,
  output var  logic                      tick_pend_q,
  output var  logic                      chip_reset_request_q,
  output var  logic                      wipe_active_state_q,
  output var  logic                      enter_sleep_q,
  output var  scx_pkg::scx_sleep_ctrl_t  sleep_ctrl_q,
  output var  logic                      wake_event_q,
  output var  logic                      event_latched_q
);

  if (NUM_IRQ < 1 || NUM_IRQ > 48) begin : g_chk_irq
    $error("NUM_IRQ must lie in 1..48 to fit a 6-bit exception number");
  end
  if (ADDR_W < 12) begin : g_chk_addr
    $error("ADDR_W must be at least 12");
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  logic [11:0] aw_addr_q;
  logic        aw_full_q;
  logic [31:0] w_data_q;
  logic        w_full_q;
  logic [31:0] strb_mask;
  logic        do_write;
  logic [31:0] wd;
  logic        sel_stat_w;
  logic        sel_rstc_w;
  logic        sel_slp_w;
  logic        key_ok;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign strb_mask[8*b +: 8] = {8{s_axi_wstrb[b]}};
  end

  assign do_write    = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wd          = w_data_q;
  assign sel_stat_w  = aw_addr_q == `SCX_STAT_OFF;
  assign sel_rstc_w  = aw_addr_q == `SCX_RSTC_OFF;
  assign sel_slp_w   = aw_addr_q == `SCX_SLP_OFF;
  // a write with a wrong key is simply dropped
  assign key_ok      = wd[`SCX_KEY_LSB +: 16] == `SCX_WRITE_KEY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      aw_addr_q     <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q     <= 1'b1;
      aw_addr_q     <= {s_axi_awaddr[11:2], 2'h0};
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // unwritten byte lanes carry zero, so a write that skips byte lane 2 or 3 cannot meet the key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q     <= 1'b1;
      w_data_q     <= s_axi_wdata & strb_mask;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCX_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (sel_stat_w || sel_rstc_w || sel_slp_w) ? `SCX_RESP_OKAY
                                                                : `SCX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending state of the two software-pendable exceptions

  logic svc_set;
  logic svc_clr;
  logic tick_set;
  logic tick_clr;

  assign svc_set  = do_write && sel_stat_w && wd[`SCX_STAT_SVC_SET];
  assign svc_clr  = (do_write && sel_stat_w && wd[`SCX_STAT_SVC_CLR]) || service_call_taken;
  assign tick_set = (do_write && sel_stat_w && wd[`SCX_STAT_TICK_SET]) || tick_event;
  assign tick_clr = (do_write && sel_stat_w && wd[`SCX_STAT_TICK_CLR]) || tick_taken;

  // set wins over clear so a fresh event is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      service_call_pend_q <= 1'b0;
    end else begin
      service_call_pend_q <= svc_set | (service_call_pend_q & ~svc_clr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_pend_q <= 1'b0;
    end else begin
      tick_pend_q <= tick_set | (tick_pend_q & ~tick_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending and active status; fixed priority, lowest exception number wins

  logic [`SCX_NUM_W-1:0] top_num;
  logic [`SCX_NUM_W-1:0] top_pend_q;
  logic                  preempt_q;
  logic                  irq_any_q;

  always_comb begin
    top_num = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pending[i] && irq_enable[i]) begin
        top_num = `SCX_NUM_W'(`SCX_IRQ_BASE + i);
      end
    end
    if (tick_pend_q) begin
      top_num = `SCX_TICK_NUM;
    end
    if (service_call_pend_q) begin
      top_num = `SCX_SVC_NUM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_pend_q <= '0;
      irq_any_q  <= 1'b0;
    end else begin
      top_pend_q <= top_num;
      irq_any_q  <= (|irq_pending) | service_call_pend_q | tick_pend_q;
    end
  end

  // a pending exception preempts on halt exit if it beats the active one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preempt_q <= 1'b0;
    end else begin
      preempt_q <= core_status.halted && (top_pend_q != '0) &&
                   (core_status.active_number == '0 ||
                    top_pend_q < core_status.active_number);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset control: keyed, write-only actions

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset_request_q <= 1'b0;
    end else if (do_write && sel_rstc_w && key_ok && wd[`SCX_RSTC_RST_REQ]) begin
      chip_reset_request_q <= 1'b1;
    end
  end

  // the block does not check the halt rule is kept; the debugger owns that
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wipe_active_state_q <= 1'b0;
    end else begin
      wipe_active_state_q <= do_write && sel_rstc_w && key_ok && wd[`SCX_RSTC_WIPE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep control

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_ctrl_q <= `SCX_SLP_RESET;
    end else if (do_write && sel_slp_w) begin
      sleep_ctrl_q.wake_on_any_pending     <= wd[`SCX_SLP_WAKE_ANY];
      sleep_ctrl_q.deep_low_power_select   <= wd[`SCX_SLP_DEEP];
      sleep_ctrl_q.sleep_on_handler_return <= wd[`SCX_SLP_SOE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enter_sleep_q <= 1'b0;
    end else begin
      enter_sleep_q <= core_status.handler_return && sleep_ctrl_q.sleep_on_handler_return;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake events from newly pending interrupts

  logic [NUM_IRQ-1:0] pend_view;
  logic [NUM_IRQ-1:0] pend_prev_q;
  logic               svc_prev_q;
  logic               tick_prev_q;
  logic               pend_event;

  assign pend_view  = sleep_ctrl_q.wake_on_any_pending ? irq_pending
                                                       : (irq_pending & irq_enable);
  assign pend_event = (|(pend_view & ~pend_prev_q)) || (service_call_pend_q && !svc_prev_q)
                      || (tick_pend_q && !tick_prev_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_prev_q <= '0;
      svc_prev_q  <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      pend_prev_q <= pend_view;
      svc_prev_q  <= service_call_pend_q;
      tick_prev_q <= tick_pend_q;
    end
  end

  scx_event_latch u_event (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .pend_event     (pend_event),
    .send_event     (core_status.send_event),
    .external_event (external_event),
    .core_waiting   (core_status.waiting_for_event),
    .wake_q         (wake_event_q),
    .latched_q      (event_latched_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address to data

  logic [31:0] stat_val;
  logic [31:0] slp_val;
  logic [11:0] ar_addr;

  assign ar_addr = {s_axi_araddr[11:2], 2'h0};

  // write-only and reserved positions stay zero
  always_comb begin
    stat_val = 32'h0000_0000;
    stat_val[`SCX_STAT_SVC_SET]  = service_call_pend_q;
    stat_val[`SCX_STAT_TICK_SET] = tick_pend_q;
    stat_val[`SCX_STAT_PREEMPT]  = preempt_q;
    stat_val[`SCX_STAT_IRQ_PEND] = irq_any_q;
    stat_val[`SCX_STAT_TOP_LSB +: `SCX_NUM_W] = top_pend_q;
    stat_val[`SCX_STAT_CUR_LSB +: `SCX_NUM_W] = core_status.active_number;
    slp_val = 32'h0000_0000;
    slp_val[`SCX_SLP_WAKE_ANY] = sleep_ctrl_q.wake_on_any_pending;
    slp_val[`SCX_SLP_DEEP]     = sleep_ctrl_q.deep_low_power_select;
    slp_val[`SCX_SLP_SOE]      = sleep_ctrl_q.sleep_on_handler_return;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SCX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SCX_RESP_OKAY;
      unique case (ar_addr)
        `SCX_STAT_OFF:  s_axi_rdata <= stat_val;
        `SCX_RSTC_OFF:  s_axi_rdata <= `SCX_RSTC_RESET;
        `SCX_SLP_OFF:   s_axi_rdata <= slp_val;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SCX_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_keyed(int bitpos);
    do_write && sel_rstc_w && key_ok && wd[bitpos];
  endsequence

  a_svc_clear: assert property (do_write && sel_stat_w && wd[`SCX_STAT_SVC_CLR] &&
                                !wd[`SCX_STAT_SVC_SET] |=> !service_call_pend_q)
    else $error("service call pending not cleared");

  a_tick_set: assert property (do_write && sel_stat_w && wd[`SCX_STAT_TICK_SET]
                               |=> tick_pend_q && s_axi_bvalid)
    else $error("tick not pending after set");

  a_tick_hold: assert property (do_write && sel_stat_w && !wd[`SCX_STAT_TICK_SET] &&
                                !wd[`SCX_STAT_TICK_CLR] && !tick_event && !tick_taken
                                |=> tick_pend_q == $past(tick_pend_q))
    else $error("tick pending changed by a zero write");

  a_top_read: assert property (s_axi_arvalid && s_axi_arready && ar_addr == `SCX_STAT_OFF
                               |=> s_axi_rvalid &&
                               s_axi_rdata[`SCX_STAT_TOP_LSB +: `SCX_NUM_W] == $past(top_pend_q))
    else $error("pending number read mismatch");

  a_rstc_read: assert property (s_axi_arvalid && s_axi_arready && ar_addr == `SCX_RSTC_OFF
                                |=> s_axi_rdata == `SCX_RSTC_RESET)
    else $error("reset control read not key pattern");

  a_reset_req: assert property (s_keyed(`SCX_RSTC_RST_REQ) |=> chip_reset_request_q [*3])
    else $error("reset request not held");

  a_bad_key: assert property (do_write && sel_rstc_w && !key_ok
                              |=> $stable(chip_reset_request_q) && !wipe_active_state_q)
    else $error("unkeyed write took effect");

  a_wipe_pulse: assert property (s_keyed(`SCX_RSTC_WIPE) |=> wipe_active_state_q ##1
                                 !wipe_active_state_q)
    else $error("wipe active not a single pulse");

  a_deep_sel: assert property (do_write && sel_slp_w
                               |=> sleep_ctrl_q.deep_low_power_select == $past(wd[`SCX_SLP_DEEP]))
    else $error("deep sleep select not written");

  a_sleep_exit: assert property (core_status.handler_return
                                 |=> enter_sleep_q == $past(sleep_ctrl_q.sleep_on_handler_return))
    else $error("sleep on handler return wrong");

endmodule
`default_nettype wire

// *** logic/scx_defines.svh ***
// register offsets, field positions and reset values of the system control registers
`ifndef SCX_DEFINES_SVH
`define SCX_DEFINES_SVH

`define SCX_STAT_OFF       12'hD04
`define SCX_RSTC_OFF       12'hD0C
`define SCX_SLP_OFF        12'hD10

`define SCX_RSTC_RESET     32'hFA05_0000
`define SCX_SLP_RESET      3'h0
`define SCX_WRITE_KEY      16'h05FA
`define SCX_KEY_LSB        16

`define SCX_STAT_SVC_SET   28
`define SCX_STAT_SVC_CLR   27
`define SCX_STAT_TICK_SET  26
`define SCX_STAT_TICK_CLR  25
`define SCX_STAT_PREEMPT   23
`define SCX_STAT_IRQ_PEND  22
`define SCX_STAT_TOP_LSB   12
`define SCX_STAT_CUR_LSB   0

`define SCX_RSTC_RST_REQ   2
`define SCX_RSTC_WIPE      1

`define SCX_SLP_WAKE_ANY   4
`define SCX_SLP_DEEP       2
`define SCX_SLP_SOE        1

`define SCX_SVC_NUM        6'h0E
`define SCX_TICK_NUM       6'h0F
`define SCX_IRQ_BASE       16
`define SCX_NUM_W          6

`define SCX_RESP_OKAY      2'h0
`define SCX_RESP_SLVERR    2'h2

`endif

// *** logic/scx_pkg.sv ***
// types shared by the system control register block
`default_nettype none
package scx_pkg;

  typedef struct packed {
    logic       halted;
    logic       waiting_for_event;
    logic       send_event;
    logic       handler_return;
    logic [5:0] active_number;
  } scx_core_status_t;

  typedef struct packed {
    logic wake_on_any_pending;
    logic deep_low_power_select;
    logic sleep_on_handler_return;
  } scx_sleep_ctrl_t;

endpackage
`default_nettype wire

// *** logic/scx_event_latch.sv ***
// wake-up event latch for a core waiting for an event
`default_nettype none
module scx_event_latch (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pend_event,
  input  wire logic send_event,
  input  wire logic external_event,
  input  wire logic core_waiting,
  output var  logic wake_q,
  output var  logic latched_q
);

  logic ev;

  assign ev = pend_event | send_event | external_event;

  // wake straight away if waiting, else keep the event for the next wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= core_waiting & (ev | latched_q);
    end
  end

  // a new event beats consumption in the same cycle only when not waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_q <= 1'b0;
    end else if (ev && !core_waiting) begin
      latched_q <= 1'b1;
    end else if (core_waiting) begin
      latched_q <= 1'b0;
    end
  end

  a_wake_now: assert property (@(posedge aclk) disable iff (!aresetn)
    core_waiting && ev |=> wake_q)
    else $error("waiting core not woken by event");

  a_latch_used: assert property (@(posedge aclk) disable iff (!aresetn)
    latched_q && core_waiting |=> wake_q && !latched_q)
    else $error("latched event not consumed by next wait");

endmodule
`default_nettype wire

// *** sim/scx_core_model.sv ***
// core-side partner: status lines, wait-for-event state and exception entry
`default_nettype none
module scx_core_model (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      halt_req,
  input  wire logic                      wait_req,
  input  wire logic                      sev_req,
  input  wire logic                      ret_req,
  input  wire logic [5:0]                active_req,
  input  wire logic [3:0]                take_delay,
  input  wire logic                      svc_pend,
  input  wire logic                      tick_pend,
  input  wire logic                      wake,
  output var  scx_pkg::scx_core_status_t core_status,
  output var  logic                      svc_taken,
  output var  logic                      tick_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       waiting_q;
  // a waiting core sleeps until the block wakes it
  always_ff @(posedge aclk) begin
    if (!aresetn || wake) waiting_q <= 1'b0;
    else if (wait_req) waiting_q <= 1'b1;
  end
  // entry take_delay+1 cycles after pending; zero means the core never takes it
  always_ff @(posedge aclk) begin
    if (!aresetn || !(svc_pend || tick_pend)) begin
      cnt_q <= 4'h0;
      svc_taken <= 1'b0;
      tick_taken <= 1'b0;
    end else if (take_delay != 4'h0 && cnt_q == take_delay) begin
      cnt_q <= 4'h0;
      svc_taken <= svc_pend;
      tick_taken <= !svc_pend;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      svc_taken <= 1'b0;
      tick_taken <= 1'b0;
    end
  end
  assign core_status = {halt_req, waiting_q, sev_req, ret_req, active_req};
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the system control register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} scx_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, irq_pending, irq_enable;
  logic [3:0]  s_axi_wstrb, take_delay;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, external_event, tick_event, service_call_taken, tick_taken;
  logic        service_call_pend_q, tick_pend_q, chip_reset_request_q, wipe_active_state_q;
  logic        enter_sleep_q, wake_event_q, event_latched_q, halt_req, wait_req, sev_req, ret_req;
  logic [5:0]  active_req;
  scx_pkg::scx_core_status_t core_status;
  scx_pkg::scx_sleep_ctrl_t  sleep_ctrl_q;
  int          errors, samples_checked, cyc, wipe_cnt, sleep_cnt, wake_cnt, w0;
  scx_row_t    rows[8] = '{
    '{12'hD10, 32'hFFFF_FFFF, 32'h0000_0016},
    '{12'hD10, 32'h0000_0000, 32'h0000_0000},
    '{12'hD04, 32'h0400_0000, 32'h0440_F000},
    '{12'hD04, 32'h0000_0000, 32'h0440_F000},
    '{12'hD04, 32'h1000_0000, 32'h1440_E000},
    '{12'hD04, 32'h0200_0000, 32'h1040_E000},
    '{12'hD04, 32'h0800_0000, 32'h0000_0000},
    '{12'hD0C, 32'h05FA_0000, 32'hFA05_0000}};

  scx_regs i_scx_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_pending,
    .irq_enable, .core_status, .external_event, .tick_event, .service_call_taken, .tick_taken,
    .service_call_pend_q, .tick_pend_q, .chip_reset_request_q, .wipe_active_state_q,
    .enter_sleep_q, .sleep_ctrl_q, .wake_event_q, .event_latched_q);
  scx_core_model i_scx_core_model (.aclk, .aresetn, .halt_req, .wait_req, .sev_req, .ret_req,
    .active_req, .take_delay, .svc_pend(service_call_pend_q), .tick_pend(tick_pend_q),
    .wake(wake_event_q), .core_status, .svc_taken(service_call_taken), .tick_taken);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters; the ceiling cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (wipe_active_state_q === 1'b1) wipe_cnt++;
    if (enter_sleep_q === 1'b1) sleep_cnt++;
    if (wake_event_q === 1'b1) wake_cnt++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: only the bench timeout ends a wait
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask

  // one wait-for-event attempt with the given wake sources
  task automatic wake_case(input logic s, input logic x, input logic [31:0] irq, input logic exp);
    int n;
    @(posedge aclk);
    wait_req <= 1'b1;
    n = wake_cnt;
    @(posedge aclk);
    wait_req <= 1'b0;
    sev_req <= s;
    external_event <= x;
    irq_pending <= irq;
    @(posedge aclk);
    sev_req <= 1'b0;
    external_event <= 1'b0;
    repeat (5) @(posedge aclk);
    check(wake_cnt != n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {irq_pending, irq_enable, take_delay, external_event, tick_event} = '0;
    {halt_req, wait_req, sev_req, ret_req, active_req} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'hD0C, 32'hFA05_0000, 2'h0);
    rd(12'hD10, 32'h0, 2'h0);
    check(sleep_ctrl_q, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 2'h0);
      rd(rows[i].a, rows[i].e, 2'h0);
    end
    wr(12'h100, 32'hFFFF_FFFF, 2'h2);
    rd(12'h100, 32'h0, 2'h2);
    irq_enable <= 32'h0A;
    irq_pending <= 32'h08;
    rd(12'hD04, 32'h0041_3000, 2'h0);
    irq_pending <= 32'h0A;
    rd(12'hD04, 32'h0041_1000, 2'h0);
    halt_req <= 1'b1;
    active_req <= 6'h20;
    repeat (3) @(posedge aclk);
    rd(12'hD04, 32'h00C1_1020, 2'h0);
    irq_enable <= 32'h0;
    // preempt flag trails the pending number by one more cycle
    repeat (2) @(posedge aclk);
    rd(12'hD04, 32'h0040_0020, 2'h0);
    check(event_latched_q, 32'h1);
    {irq_pending, halt_req, active_req} <= '0;
    wake_case(1'b0, 1'b0, 32'h0, 1'b1);
    wake_case(1'b1, 1'b0, 32'h0, 1'b1);
    wake_case(1'b0, 1'b1, 32'h0, 1'b1);
    wake_case(1'b0, 1'b0, 32'h0, 1'b0);
    wake_case(1'b0, 1'b0, 32'h20, 1'b0);
    wr(12'hD10, 32'h10, 2'h0);
    // the still-waiting core wakes on the held disabled line; let that pulse pass
    repeat (2) @(posedge aclk);
    wake_case(1'b0, 1'b0, 32'h60, 1'b1);
    irq_pending <= 32'h0;
    take_delay <= 4'h3;
    tick_event <= 1'b1;
    @(posedge aclk);
    tick_event <= 1'b0;
    repeat (2) @(posedge aclk);
    check(tick_pend_q, 32'h1);
    repeat (8) @(posedge aclk);
    check(tick_pend_q, 32'h0);
    wr(12'hD0C, 32'h1234_0004, 2'h0);
    repeat (2) @(posedge aclk);
    check(chip_reset_request_q, 32'h0);
    wr(12'hD0C, 32'h05FA_0004, 2'h0);
    repeat (2) @(posedge aclk);
    check(chip_reset_request_q, 32'h1);
    rd(12'hD0C, 32'hFA05_0000, 2'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check(chip_reset_request_q, 32'h0);
    w0 = wipe_cnt;
    halt_req <= 1'b1;
    wr(12'hD0C, 32'h05FA_0002, 2'h0);
    repeat (4) @(posedge aclk);
    check(wipe_cnt - w0, 32'h1);
    halt_req <= 1'b0;
    wr(12'hD10, 32'h6, 2'h0);
    repeat (2) @(posedge aclk);
    check(sleep_ctrl_q, 32'h3);
    w0 = sleep_cnt;
    for (int j = 0; j < 2; j++) begin
      ret_req <= 1'b1;
      @(posedge aclk);
      ret_req <= 1'b0;
      repeat (3) @(posedge aclk);
      check(sleep_cnt - w0, 32'h1);
      wr(12'hD10, 32'h0, 2'h0);
    end
    test_done();
  end
endmodule
`default_nettype wire
